// ---- include/spc_pkg.sv ----
package spc_pkg;

  // ----------------------------------------------------------------
  // Register map, byte offsets on the AXI4-Lite slave.
  // ----------------------------------------------------------------
  localparam int AW = 8;
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;   // Current level.
  localparam logic [AW-1:0] OFS_FLAGS = 8'h04;  // Processor flags word.
  localparam logic [AW-1:0] OFS_SEL = 8'h08;    // Selector operand.
  localparam logic [AW-1:0] OFS_DLO = 8'h0C;    // Descriptor bytes 0 to 3.
  localparam logic [AW-1:0] OFS_DHI = 8'h10;    // Descriptor bytes 4 to 7.
  localparam logic [AW-1:0] OFS_CMD = 8'h14;    // Command, starts a check.
  localparam logic [AW-1:0] OFS_STAT = 8'h18;   // Outcome of the last check.
  localparam logic [AW-1:0] OFS_RES = 8'h1C;    // Result word.
  localparam logic [AW-1:0] OFS_OFF = 8'h20;    // Offset for access checks.
  localparam logic [AW-1:0] OFS_SSEL = 8'h40;   // Segment selectors, 4 bytes each.
  localparam logic [AW-1:0] OFS_SCACHE = 8'h80; // Descriptor caches, 8 bytes each.

  // ----------------------------------------------------------------
  // Field positions, reset values and codes.
  // ----------------------------------------------------------------
  localparam int TH_LSB = 13;   // Port access threshold sits in bits 14:13.
  localparam int NEST_BIT = 15; // Nested task flag.
  localparam int ACC_POS = 40;  // Accessed bit within a cached descriptor.
  localparam int T_EXEC = 3;
  localparam int T_DIR = 2;
  localparam int T_RW = 1;
  localparam logic [1:0] RST_LEVEL = 2'h0;
  localparam logic [31:0] RST_FLAGS = 32'h0000_0000;
  localparam logic [2:0] SEG_CS = 3'h0;
  localparam logic [2:0] SEG_SS = 3'h1;
  localparam logic [7:0] VEC_NP = 8'h0B;
  localparam logic [7:0] VEC_SS = 8'h0C;
  localparam logic [7:0] VEC_GP = 8'h0D;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic [2:0] GT_TASK_BLOCK = 3'h1;
  localparam logic [2:0] GT_CALL = 3'h4;
  localparam logic [2:0] GT_TASK = 3'h5;
  localparam logic [1:0] GT_INTR = 2'h3;
  localparam logic [11:0] PAGE_FILL = 12'hFFF;

  typedef enum logic {ST_IDLE, ST_EXEC} spc_fsm_t;
  typedef enum logic [3:0] {OP_NONE, OP_LOAD, OP_GATE, OP_IO, OP_ADJ, OP_TEST, OP_XFER,
                            OP_ACC} spc_op_t;
  typedef enum logic [2:0] {K_JMP, K_CALL, K_RET, K_IRET, K_INT} spc_kind_t;
  typedef enum logic [2:0] {XC_NONE, XC_SAME, XC_GATE, XC_INTG, XC_LOWER, XC_TASK,
                            XC_BAD} spc_xc_t;

  // ----------------------------------------------------------------
  // Carriers.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] base_hi; logic g; logic db; logic zero; logic avl; logic [3:0] lim_hi;
    logic p; logic [1:0] descriptor_level; logic s; logic [3:0] typ;
    logic [7:0] base_mid; logic [15:0] base_lo; logic [15:0] lim_lo;
  } spc_desc_t;
  typedef struct packed {
    logic [12:0] index; logic tsel; logic [1:0] requestor_level;
  } spc_sel_t;
  typedef struct packed {
    logic [14:0] rsvd; logic native; logic [4:0] count; logic wr; spc_kind_t kind;
    logic [2:0] seg; spc_op_t op;
  } spc_cmd_t;
  typedef struct packed {
    logic [12:0] index; spc_xc_t xclass; logic legacy; logic tsel; logic [1:0] requestor_level;
    logic [1:0] effective_level; logic busy; logic fault; logic [7:0] vector;
  } spc_stat_t;
  typedef struct packed {
    logic awvalid; logic [AW-1:0] awaddr; logic wvalid; logic [31:0] wdata;
    logic [3:0] wstrb; logic bready; logic arvalid; logic [AW-1:0] araddr; logic rready;
  } spc_axi_req_t;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } spc_axi_rsp_t;

endpackage : spc_pkg

// ---- verilog/spc_checker.sv ----
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Type bit 3 clear: data; bit 2 picks limit.
// - Data writes allowed only with type bit 1.
// - Type bit 3 set: code; bit 1 allows reads.
// - Conforming code needs current >= descriptor level.
// - Loads and selector tests set accessed bit.
// - Upper 16 bits zero marks legacy system format.
// - Gate copies word count items, 16/32-bit.
// - Selector splits into table, index, requestor level.
// - Segment load fills hidden descriptor cache.
// - Four levels, 0 most privileged.
// - Only gate transfers change current level; here a write to OFS_CTRL also sets it.
// - Effective level is larger of current, requestor.
// - Adjust instruction raises requestor level to current.
// - Port threshold lives in flag bits 14:13.
// - Current above threshold faults I/O with 13.
// - Data register loads need data or readable code.
// - Privilege check raises 13 on violation.
// - Stack load needs writable data, equal levels.
// - Not-present stack segment raises 12.
// - Nested task flag decides interrupt return kind.
// - Data reachable only from equal or better level.
// - Calls reach code only from equal or worse.
// - Code register load is intersegment control transfer.
// - Not-present segment raises 11.
// - System bit 1 means code or data.
// - Upper 13 selector bits index the table.
// - Low two selector bits give requestor level.
module spc_checker #(
  parameter int NSEG = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire spc_pkg::spc_axi_req_t axi_req,
  output logic [1:0] current_level,
  output logic fault,
  output spc_pkg::spc_axi_rsp_t axi_rsp
);
  import spc_pkg::*;

  // ----------------------------------------------------------------
  // State of the block, held as one record.
  // ----------------------------------------------------------------
  typedef struct packed {
    spc_fsm_t fsm;
    logic aw_got;                      // Write address captured.
    logic [AW-1:0] aw_addr;
    logic w_got;                       // Write data captured.
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] current_level;         // Current level.
    logic [31:0] flags;                // Processor flags word.
    logic [15:0] sel;                  // Selector operand.
    logic [63:0] desc;                 // Descriptor operand.
    logic [31:0] offset;               // Offset operand.
    spc_cmd_t cmd;
    spc_stat_t stat;
    logic [31:0] result;
    logic [NSEG-1:0][15:0] seg_sel;    // Visible segment registers.
    logic [NSEG-1:0][63:0] seg_cache;  // Hidden descriptor caches.
  } spc_state_t;

  spc_state_t st;
  spc_state_t nx;

  // ----------------------------------------------------------------
  // Helper functions.
  // ----------------------------------------------------------------
  // Numerically larger level, which is the less privileged one.
  function automatic logic [1:0] fn_max2(input logic [1:0] a, input logic [1:0] b);
    return (a > b) ? a : b;
  endfunction : fn_max2
  // Byte-lane merge of a write into an old word.
  function automatic logic [31:0] fn_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      m[8*b +: 8] = strb[b] ? nw[8*b +: 8] : m[8*b +: 8];
    end
    return m;
  endfunction : fn_merge

  // Read decode; returns the response code above the data.
  function automatic logic [33:0] fn_read(input logic [AW-1:0] a, input spc_state_t s);
    logic [AW-1:0] r;
    logic [63:0] w;
    if (a == OFS_CTRL) begin
      return {RESP_OK, 30'h0, s.current_level};
    end else if (a == OFS_FLAGS) begin
      return {RESP_OK, s.flags};
    end else if (a == OFS_SEL) begin
      return {RESP_OK, 16'h0, s.sel};
    end else if (a == OFS_DLO) begin
      return {RESP_OK, s.desc[31:0]};
    end else if (a == OFS_DHI) begin
      return {RESP_OK, s.desc[63:32]};
    end else if (a == OFS_CMD) begin
      return {RESP_OK, s.cmd};
    end else if (a == OFS_STAT) begin
      return {RESP_OK, s.stat};
    end else if (a == OFS_RES) begin
      return {RESP_OK, s.result};
    end else if (a == OFS_OFF) begin
      return {RESP_OK, s.offset};
    end else if (a >= OFS_SSEL && a < OFS_SCACHE) begin
      r = a - OFS_SSEL;
      if (r < AW'(4 * NSEG)) begin
        return {RESP_OK, 16'h0, s.seg_sel[r[AW-1:2]]};
      end
    end else if (a >= OFS_SCACHE) begin
      r = a - OFS_SCACHE;
      if (r < AW'(8 * NSEG)) begin
        w = s.seg_cache[r[AW-1:3]];
        return {RESP_OK, (r[2] ? w[63:32] : w[31:0])};
      end
    end
    return {RESP_ERR, 32'h0};
  endfunction : fn_read

  // ----------------------------------------------------------------
  // Operand decode.
  // ----------------------------------------------------------------
  spc_desc_t d;       // Descriptor operand viewed by field.
  spc_sel_t s;        // Selector operand viewed by field.
  logic [1:0] effective_level;  // Effective level.
  logic is_code;
  logic is_data;
  logic conf;         // Conforming code.
  logic legacy;       // Legacy system format.
  logic seg_ok;       // Segment number names a register.

  assign d = spc_desc_t'(st.desc);
  assign s = spc_sel_t'(st.sel);
  assign effective_level = fn_max2(st.current_level, s.requestor_level);
  assign is_code = d.s && d.typ[T_EXEC];
  assign is_data = d.s && !d.typ[T_EXEC];
  assign conf = is_code && d.typ[T_DIR];
  assign legacy = (st.desc[63:48] == 16'h0000);
  assign seg_ok = (int'(st.cmd.seg) < NSEG);

  // ----------------------------------------------------------------
  // Next state: bus slave, register writes and the checks.
  // ----------------------------------------------------------------
  // A command write is answered once its check is done, so a later read sees the outcome.
  always_comb begin
    spc_desc_t cd;
    logic [31:0] lim;
    logic [31:0] wm;
    logic gp;
    logic np_f;
    logic [7:0] vec;
    spc_xc_t xc;
    nx = st;
    cd = '0;
    lim = '0;
    wm = '0;
    gp = 1'b0;
    np_f = 1'b0;
    vec = VEC_NP;
    xc = XC_NONE;

    // Address and data channels are taken in either order.
    if (axi_req.awvalid && st.awready) begin
      nx.aw_got = 1'b1;
      nx.aw_addr = axi_req.awaddr;
      nx.awready = 1'b0;
    end
    if (axi_req.wvalid && st.wready) begin
      nx.w_got = 1'b1;
      nx.w_data = axi_req.wdata;
      nx.w_strb = axi_req.wstrb;
      nx.wready = 1'b0;
    end

    // Perform the write once both halves are in.
    if (st.aw_got && st.w_got && !st.bvalid) begin
      nx.aw_got = 1'b0;
      nx.w_got = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp = RESP_OK;
      if (st.aw_addr == OFS_CTRL) begin
        wm = fn_merge({30'h0, st.current_level}, st.w_data, st.w_strb);
        nx.current_level = wm[1:0];
      end else if (st.aw_addr == OFS_FLAGS) begin
        nx.flags = fn_merge(st.flags, st.w_data, st.w_strb);
      end else if (st.aw_addr == OFS_SEL) begin
        wm = fn_merge({16'h0, st.sel}, st.w_data, st.w_strb);
        nx.sel = wm[15:0];
      end else if (st.aw_addr == OFS_DLO) begin
        nx.desc[31:0] = fn_merge(st.desc[31:0], st.w_data, st.w_strb);
      end else if (st.aw_addr == OFS_DHI) begin
        nx.desc[63:32] = fn_merge(st.desc[63:32], st.w_data, st.w_strb);
      end else if (st.aw_addr == OFS_CMD) begin
        // The response waits for the check.
        nx.cmd = spc_cmd_t'(fn_merge(st.cmd, st.w_data, st.w_strb));
        nx.fsm = ST_EXEC;
        nx.stat.busy = 1'b1;
        nx.bvalid = 1'b0;
      end else if (st.aw_addr == OFS_OFF) begin
        nx.offset = fn_merge(st.offset, st.w_data, st.w_strb);
      end else begin
        // Unmapped or read-only: nothing changes.
        nx.bresp = RESP_ERR;
      end
    end
    if (st.bvalid && axi_req.bready) begin
      nx.bvalid = 1'b0;
      nx.awready = 1'b1;
      nx.wready = 1'b1;
    end

    // Read channel: one read under way at a time.
    if (axi_req.arvalid && st.arready) begin
      nx.arready = 1'b0;
      nx.rvalid = 1'b1;
      {nx.rresp, nx.rdata} = fn_read(axi_req.araddr, st);
    end
    if (st.rvalid && axi_req.rready) begin
      nx.rvalid = 1'b0;
      nx.arready = 1'b1;
    end

    case (st.fsm)
      ST_EXEC: begin
        nx.fsm = ST_IDLE;
        nx.stat.busy = 1'b0;
        nx.bvalid = 1'b1;
        nx.bresp = RESP_OK;
        nx.stat.index = s.index;
        nx.stat.tsel = s.tsel;
        nx.stat.requestor_level = s.requestor_level;
        nx.stat.effective_level = effective_level;
        nx.stat.legacy = !d.s && legacy;
        case (st.cmd.op)
          OP_LOAD: begin
            if (!seg_ok) begin
              gp = 1'b1;
            end else if (st.cmd.seg == SEG_CS) begin
              // A plain code load keeps the level; conforming code runs at it.
              gp = !is_code || (conf ? (st.current_level < d.descriptor_level)
                                     : (d.descriptor_level != st.current_level
                                        || s.requestor_level > st.current_level));
              np_f = !d.p;
            end else if (st.cmd.seg == SEG_SS) begin
              gp = !is_data || !d.typ[T_RW] || d.descriptor_level != st.current_level
                   || s.requestor_level != st.current_level;
              np_f = !d.p;
              vec = VEC_SS;
            end else begin
              gp = !(is_data || (is_code && d.typ[T_RW]));
              // Conforming code is exempt from the level comparison.
              gp = gp || (!conf && d.descriptor_level < effective_level);
              np_f = !d.p;
            end
            if (!gp && !np_f) begin
              nx.seg_sel[st.cmd.seg] = st.sel;
              nx.seg_cache[st.cmd.seg] = st.desc;
              nx.seg_cache[st.cmd.seg][ACC_POS] = 1'b1;
            end
          end
          OP_GATE: begin
            // The operand is the gate's target code descriptor.
            gp = !is_code || d.descriptor_level > st.current_level;
            np_f = !d.p;
            if (!gp && !np_f) begin
              if (!conf) begin
                nx.current_level = d.descriptor_level;
              end
              nx.seg_sel[SEG_CS] = st.sel;
              nx.seg_cache[SEG_CS] = st.desc;
              nx.seg_cache[SEG_CS][ACC_POS] = 1'b1;
              // Bytes of stack to copy.
              nx.result = 32'(st.cmd.count) << (st.cmd.native ? 2 : 1);
            end
          end
          OP_IO: begin
            gp = st.current_level > st.flags[TH_LSB +: 2];
          end
          OP_ADJ: begin
            nx.result = {16'h0, s.index, s.tsel, effective_level};
          end
          OP_TEST: begin
            nx.desc[ACC_POS] = 1'b1;
          end
          OP_XFER: begin
            case (st.cmd.kind)
              K_RET, K_IRET: begin
                if (st.cmd.kind == K_IRET && st.flags[NEST_BIT]) begin
                  xc = XC_TASK;
                end else if (is_code) begin
                  xc = (d.descriptor_level > st.current_level) ? XC_LOWER : XC_SAME;
                end else begin
                  xc = XC_BAD;
                end
              end
              K_JMP, K_CALL: begin
                if (is_code) begin
                  xc = XC_SAME;
                end else if (!d.s && d.typ[2:0] == GT_CALL && st.cmd.kind == K_CALL) begin
                  xc = XC_GATE;
                end else if (!d.s && (d.typ[2:0] == GT_TASK
                                      || (d.typ[2:0] == GT_TASK_BLOCK && !s.tsel))) begin
                  xc = XC_TASK;
                end else begin
                  xc = XC_BAD;
                end
              end
              K_INT: begin
                if (!d.s && d.typ[2:1] == GT_INTR) begin
                  xc = XC_INTG;
                end else if (!d.s && d.typ[2:0] == GT_TASK) begin
                  xc = XC_TASK;
                end else begin
                  xc = XC_BAD;
                end
              end
              default: begin
                xc = XC_BAD;
              end
            endcase
            gp = (xc == XC_BAD);
          end
          OP_ACC: begin
            if (seg_ok) begin
              cd = spc_desc_t'(st.seg_cache[st.cmd.seg]);
            end
            // Page granular limits fill the low twelve bits.
            lim = cd.g ? {cd.lim_hi, cd.lim_lo, PAGE_FILL} : {12'h0, cd.lim_hi, cd.lim_lo};
            if (!seg_ok || !cd.s || !cd.p) begin
              gp = 1'b1;
            end else if (cd.typ[T_EXEC]) begin
              gp = st.cmd.wr || !cd.typ[T_RW];
            end else begin
              gp = (st.cmd.wr && !cd.typ[T_RW])
                   || (cd.typ[T_DIR] ? (st.offset <= lim) : (st.offset > lim));
            end
          end
          OP_NONE: begin
          end
          default: begin
            gp = 1'b1;
          end
        endcase
        nx.stat.xclass = xc;
        nx.stat.fault = gp || np_f;
        nx.stat.vector = gp ? VEC_GP : (np_f ? vec : 8'h00);
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.current_level <= RST_LEVEL;
      st.flags <= RST_FLAGS;
    end else begin
      st <= nx;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, each taken straight from the state register.
  // ----------------------------------------------------------------
  assign current_level = st.current_level;
  assign fault = st.stat.fault;
  assign axi_rsp.awready = st.awready;
  assign axi_rsp.wready = st.wready;
  assign axi_rsp.bvalid = st.bvalid;
  assign axi_rsp.bresp = st.bresp;
  assign axi_rsp.arready = st.arready;
  assign axi_rsp.rvalid = st.rvalid;
  assign axi_rsp.rdata = st.rdata;
  assign axi_rsp.rresp = st.rresp;

endmodule : spc_checker

`default_nettype wire

// ---- tb/spc_prot_checker.sv ----
`timescale 1ns/1ns
`default_nettype none

module spc_prot_checker #(
  parameter int NSEG = 6  // Segment count, handed on from the block.
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire spc_pkg::spc_axi_req_t axi_req,
  input wire logic [1:0] current_level,
  input wire logic fault,
  input wire spc_pkg::spc_axi_rsp_t axi_rsp
);
  import spc_pkg::*;

  // --------------------------------------------------------------
  // Bus timing and state changes seen at the ports.
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Both write channels are taken at one edge.
  sequence s_wtake;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  // One quiet cycle, then the answer; a command needs one cycle more.
  sequence s_wans;
    !axi_rsp.bvalid && !axi_rsp.awready ##[1:2] axi_rsp.bvalid;
  endsequence
  property p_wr_ans;
    s_wtake |=> s_wans;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer out of time");
  property p_b_end;
    axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid && axi_rsp.wready;
  endproperty
  a_b_end: assert property (p_b_end) else $error("write answer not closed");
  property p_rd_ans;
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer out of time");
  property p_r_end;
    axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid && axi_rsp.arready;
  endproperty
  a_r_end: assert property (p_r_end) else $error("read answer not closed");
  // A refused read must not leak stale data.
  property p_r_err;
    axi_rsp.rvalid && axi_rsp.rresp != RESP_OK |-> axi_rsp.rdata == 32'h0;
  endproperty
  a_r_err: assert property (p_r_err) else $error("refused read carries data");
  // The level moves only as a write or a command completes.
  property p_lvl;
    !$stable(current_level) |-> ##[0:2] axi_rsp.bvalid;
  endproperty
  a_lvl: assert property (p_lvl) else $error("level moved on its own");
  property p_flt;
    $changed(fault) |-> ##[0:2] axi_rsp.bvalid;
  endproperty
  a_flt: assert property (p_flt) else $error("fault moved on its own");
  property p_b_code;
    axi_rsp.bvalid |-> axi_rsp.bresp == RESP_OK || axi_rsp.bresp == RESP_ERR;
  endproperty
  a_b_code: assert property (p_b_code) else $error("bad write response");
endmodule : spc_prot_checker

bind spc_checker spc_prot_checker #(.NSEG(NSEG)) i_prot_chk (.clk(clk), .rst_n(rst_n),
  .axi_req(axi_req), .current_level(current_level), .fault(fault), .axi_rsp(axi_rsp));

`default_nettype wire

// ---- tb/spc_checker_bench.sv ----
`timescale 1ns/1ns
`default_nettype none

module spc_checker_bench;
  import spc_pkg::*;

  // ----------------------------------------------------------------
  // Clock, reset, block and bookkeeping.
  // ----------------------------------------------------------------
  localparam int LIMIT = 5000;  // The run needs about 560 cycles.
  localparam logic [8:0] OK = 9'h000;
  localparam logic [8:0] GP = {1'b1, VEC_GP};
  localparam logic [8:0] NP = {1'b1, VEC_NP};
  localparam logic [8:0] SNP = {1'b1, VEC_SS};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  spc_axi_req_t req;
  spc_axi_rsp_t rsp;
  logic [1:0] current_level;
  logic fault;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rdv;  // Scratch read data.
  logic [1:0] rrs;   // Scratch read response.
  // Access cases: access byte, offset, write flag, fault expected. Limit is 0x100.
  logic [27:0] acc_tab [8] = '{28'hD210010, 28'hD210101, 28'hD001011, 28'hD001000,
                               28'hD610001, 28'hD610110, 28'hDA01000, 28'hDA01011};

  always #50 clk = ~clk;

  spc_checker #(.NSEG(6)) i_dut (.clk(clk), .rst_n(rst_n), .axi_req(req),
    .current_level(current_level), .fault(fault), .axi_rsp(rsp));

  // A hang counts as a mismatch and ends the run.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks; bready and rready stay high, so no answer is ever stalled.
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // Address and data go out together; each drops once it is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OK);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    do begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    chk({30'h0, rsp.bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    d = rsp.rdata;
    r = rsp.rresp;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OK);
    rd(a, rdv, rrs);
    chk(rdv, e);
    chk({30'h0, rrs}, {30'h0, er});
  endtask : rc

  // Runs a check, then compares fault and vector in the status and on the pin.
  task automatic cmd(input logic [31:0] c, input logic [8:0] e);
    wr(OFS_CMD, c);
    rd(OFS_STAT, rdv, rrs);
    chk({23'h0, rdv[8:0]}, {23'h0, e});
    chk({31'h0, fault}, {31'h0, e[8]});
  endtask : cmd

  // Loads a segment register from a selector and an access byte.
  task automatic ld(input logic [2:0] sg, input logic [15:0] s, input logic [7:0] ab,
                    input logic [8:0] e);
    wr(OFS_SEL, {16'h0, s});
    wr(OFS_DLO, 32'h0000_0100);
    wr(OFS_DHI, {16'h0, ab, 8'h00});
    cmd({25'h0, sg, 4'h1}, e);
  endtask : ld

  // Selector test: index, table select, requestor and effective level.
  task automatic st(input logic [15:0] s, input logic [17:0] e);
    wr(OFS_SEL, {16'h0, s});
    wr(OFS_CMD, 32'h5);
    rd(OFS_STAT, rdv, rrs);
    chk({14'h0, rdv[31:19], rdv[14:10]}, {14'h0, e});
  endtask : st

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    req = '0;
    req.wstrb = 4'hF;
    req.bready = 1'b1;
    req.rready = 1'b1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc(OFS_CTRL, 32'h0);
    rc(OFS_FLAGS, 32'h0);
    rc(8'h24, 32'h0, RESP_ERR);
    wr(8'h24, 32'h1, RESP_ERR);
    wr(OFS_STAT, 32'h1, RESP_ERR);
    wr(OFS_CTRL, 32'h2);
    chk({30'h0, current_level}, 32'h2);
    // Level 2 against every threshold value.
    for (int t = 0; t < 4; t++) begin
      wr(OFS_FLAGS, 32'(t << TH_LSB));
      cmd(32'h3, (t < 2) ? GP : OK);
    end
    wr(OFS_SEL, 32'h0029);
    cmd(32'h4, OK);
    rc(OFS_RES, 32'h002A);
    st(16'hD5E7, {13'h1ABC, 5'h1F});
    rc(OFS_DHI, 32'h100);
    st(16'h0009, {13'h0001, 5'h06});
    // Data register loads, then data refused for the code register; failures must leave register and cache alone.
    ld(3'h2, 16'h0012, 8'hD2, OK);
    rc(OFS_SSEL + 8'h08, 32'h12);
    rc(OFS_SCACHE + 8'h10, 32'h100);
    rc(OFS_SCACHE + 8'h14, 32'hD300);
    ld(3'h3, 16'h0012, 8'hB2, GP);
    ld(3'h3, 16'h0013, 8'hD2, GP);
    ld(3'h3, 16'h0012, 8'hF8, GP);
    ld(3'h3, 16'h0012, 8'h52, NP);
    rc(OFS_SSEL + 8'h0C, 32'h0);
    rc(OFS_SCACHE + 8'h1C, 32'h0);
    ld(SEG_CS, 16'h0012, 8'hD2, GP);
    // Stack loads.
    ld(SEG_SS, 16'h0012, 8'hD2, OK);
    ld(SEG_SS, 16'h0022, 8'hD0, GP);
    ld(SEG_SS, 16'h0022, 8'hF2, GP);
    ld(SEG_SS, 16'h0023, 8'hD2, GP);
    ld(SEG_SS, 16'h0022, 8'h52, SNP);
    rc(OFS_SSEL + 8'h04, 32'h12);
    // Access checks through the cache of data register 2.
    for (int i = 0; i < 8; i++) begin
      ld(3'h2, 16'h0012, acc_tab[i][27:20], OK);
      wr(OFS_OFF, {20'h0, acc_tab[i][19:8]});
      cmd({21'h0, acc_tab[i][4], 3'h0, 3'h2, 4'h7}, acc_tab[i][0] ? GP : OK);
    end
    // Gate calls at level 2 with three stack items.
    wr(OFS_DHI, 32'h9A00);
    cmd(32'h1802, OK);
    rc(OFS_RES, 32'h6);
    chk({30'h0, current_level}, 32'h0);
    wr(OFS_CTRL, 32'h2);
    cmd(32'h11802, OK);
    rc(OFS_RES, 32'hC);
    wr(OFS_CTRL, 32'h2);
    wr(OFS_DHI, 32'hFA00);
    cmd(32'h1802, GP);
    wr(OFS_DHI, 32'hFE00);
    cmd(32'h1802, GP);
    wr(OFS_DHI, 32'hBE00);
    cmd(32'h1802, OK);
    chk({30'h0, current_level}, 32'h2);
    // Returns: the nested flag turns an interrupt return into a task switch.
    wr(OFS_FLAGS, 32'(1 << NEST_BIT));
    cmd(32'h186, OK);
    chk({29'h0, rdv[18:16]}, {29'h0, XC_TASK});
    wr(OFS_FLAGS, 32'h0);
    wr(OFS_DHI, 32'hFA00);
    cmd(32'h186, OK);
    chk({29'h0, rdv[18:16]}, {29'h0, XC_LOWER});
    // A task gate with a zero upper half is in the legacy system format.
    wr(OFS_DHI, 32'h8500);
    cmd(32'h6, OK);
    chk({28'h0, rdv[18:15]}, {28'h0, XC_TASK, 1'b1});
    wr(OFS_DHI, 32'h0001_8500);
    cmd(32'h6, OK);
    chk({28'h0, rdv[18:15]}, {28'h0, XC_TASK, 1'b0});
    report_and_stop();
  end
endmodule : spc_checker_bench

`default_nettype wire
